/* File: hw/wave_pkg.sv */
package wave_pkg;
  // ==========================================================
  // bus map, byte addresses
  localparam logic [5:0] OFS_TABLE0 = 6'h00;
  localparam logic [5:0] OFS_SELECT = 6'h20;
  localparam logic [5:0] OFS_START = 6'h24;
  localparam logic [5:0] OFS_COUNTER = 6'h28;
  localparam logic [5:0] OFS_CURRENT = 6'h2C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // table geometry
  localparam int TABLE_WORDS = 8;
  localparam int WORD_W = 32;
  localparam int POS_W = 10;
  localparam int CUR_W = 9;
  localparam logic [9:0] POS_ZERO = 10'h000;
  localparam logic [9:0] POS_ONE = 10'h001;
  localparam logic [9:0] QUARTER_POS = 10'h100;
  localparam logic [8:0] QUARTER_IDX = 9'h100;
  // ==========================================================
  // segment select fields
  localparam int SLOPE_W = 2;
  localparam int BOUND_W = 8;
  localparam int SEL_SLOPE_LSB = 0;
  localparam int SEL_BOUND1_LSB = 8;
  localparam int SEL_BOUND2_LSB = 16;
  localparam int SEL_BOUND3_LSB = 24;
  localparam logic signed [2:0] SLOPE_BIAS = 3'sh1;
  // ==========================================================
  // start config fields
  localparam int START_W = 8;
  localparam int SINE_START_VALUE_LSB = 0;
  localparam int START_COS_LSB = 16;
  localparam int COS_OFS_LSB = 24;
  // ==========================================================
  // reset values
  localparam logic [31:0] TABLE_RESET [TABLE_WORDS] = '{
    32'hAAAAB554, 32'h4A9554AA, 32'h24492929, 32'h10104222,
    32'h0FBFFFFF, 32'h49295556, 32'h00000000, 32'h00404222};
  localparam logic [31:0] SELECT_RESET = 32'hFFFF8056;
  localparam logic [31:0] START_RESET = 32'h00F70000;
endpackage : wave_pkg

/* File: hw/wave_segment_pick.sv */
`timescale 1ns/100ps
module wave_segment_pick
  import wave_pkg::*;
(
  input logic [31:0] seg_select,
  input logic [7:0] index,
  output logic [1:0] segment,
  output logic signed [2:0] base_slope
);
  // ==========================================================
  // segment lookup
  logic [7:0] segment_bound_1;
  logic [7:0] segment_bound_2;
  logic [7:0] segment_bound_3;
  logic [1:0] code;

  assign segment_bound_1 = seg_select[SEL_BOUND1_LSB +: BOUND_W];
  assign segment_bound_2 = seg_select[SEL_BOUND2_LSB +: BOUND_W];
  assign segment_bound_3 = seg_select[SEL_BOUND3_LSB +: BOUND_W];

  // first bound above the index wins
  always_comb begin
    if (index < segment_bound_1) begin
      segment = 2'h0;
    end else if (index < segment_bound_2) begin
      segment = 2'h1;
    end else if (index < segment_bound_3) begin
      segment = 2'h2;
    end else begin
      segment = 2'h3;
    end
  end

  // codes 0..3 stand for slopes -1..2
  assign code = seg_select[SEL_SLOPE_LSB + SLOPE_W * segment +: SLOPE_W];
  assign base_slope = $signed({1'b0, code}) - SLOPE_BIAS;
endmodule : wave_segment_pick

/* File: hw/wave_table_mem.sv */
`timescale 1ns/100ps
module wave_table_mem
  import wave_pkg::*;
#(
  parameter int WORDS = TABLE_WORDS,
  parameter int WIDTH = WORD_W
) (
  input logic aclk,
  input logic aresetn,
  input logic wr_en,
  input logic [$clog2(WORDS)-1:0] wr_addr,
  input logic [WIDTH-1:0] wr_data,
  input logic [WIDTH/8-1:0] wr_strb,
  input logic [$clog2(WORDS)-1:0] bus_addr,
  output logic [WIDTH-1:0] bus_data,
  input logic [$clog2(WORDS)-1:0] walk_addr,
  output logic [WIDTH-1:0] walk_data
);
  // ==========================================================
  // reset image only exists for the documented geometry
  if (WORDS != TABLE_WORDS || WIDTH != WORD_W) begin : g_bad_size
    $error("wave_table_mem: unsupported geometry");
  end

  logic [WIDTH-1:0] mem_ff [WORDS];
  logic [WIDTH-1:0] bus_data_ff;
  logic [WIDTH-1:0] walk_data_ff;

  // storage with byte lanes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_ff[i] <= TABLE_RESET[i];
      end
    end else if (wr_en) begin
      for (int b = 0; b < WIDTH / 8; b++) begin
        if (wr_strb[b]) begin
          mem_ff[wr_addr][8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  end

  // two registered read ports, one for software, one for the walk
  always_ff @(posedge aclk) begin
    bus_data_ff <= mem_ff[bus_addr];
    walk_data_ff <= mem_ff[walk_addr];
  end

  assign bus_data = bus_data_ff;
  assign walk_data = walk_data_ff;
endmodule : wave_table_mem

/* File: hw/wave_table_core.sv */
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
// Contract
// - store only quarter wave, mirror to full period, 10-bit microstep counter addresses
// - 256 one-bit increments packed in eight 32-bit table words
// - each step adds base slope, plus one when the entry bit is set
// - base slope programmable to -1, 0, 1 or 2
// - three bounds split quarter into four segments, each with own slope
// - every microstep computes and stores both coil current values
// - both coil values reload start values whenever the counter lands on zero
// - programmable sine start value gives output at position zero
// - second start value holds cosine entry, shifted by 256 microsteps
// - signed cosine offset -128..+127 shifts the second coil wave
// - table words and start config reset to their default values
// - default segment word: bounds 128, 255, 255; slopes coded 10,01,01,01
module wave_table_core
  import wave_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic [5:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [5:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic step_pulse,
  input logic step_dir,
  output logic [POS_W-1:0] microstep_counter,
  output logic signed [CUR_W-1:0] coil_a_current,
  output logic signed [CUR_W-1:0] coil_b_current
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH_A, ST_APPLY_A, ST_FETCH_B, ST_APPLY_B
  } walk_state_e;

  // quarter index of a full-wave position; odd quadrants run backwards
  function automatic logic [8:0] quarter_index(input logic [9:0] pos);
    quarter_index = pos[8] ? QUARTER_IDX - {1'b0, pos[7:0]} : {1'b0, pos[7:0]};
  endfunction : quarter_index

  // ==========================================================
  // declarations
  walk_state_e state_ff;
  logic [9:0] pos_ff;
  logic [9:0] new_pos_ff;
  logic signed [8:0] mag_a_ff;
  logic signed [8:0] mag_b_ff;
  logic signed [8:0] coil_a_ff;
  logic signed [8:0] coil_b_ff;
  logic [31:0] seg_select_ff;
  logic [31:0] start_cfg_ff;
  logic [9:0] cos_offset;
  logic walk_b;
  logic [9:0] old_b;
  logic [9:0] new_b;
  logic [9:0] cur_old;
  logic [9:0] cur_new;
  logic [8:0] idx_old;
  logic [8:0] idx_new;
  logic rising;
  logic [8:0] walk_k;
  logic [7:0] walk_index;
  logic [31:0] walk_word;
  logic table_bit;
  logic [1:0] segment;
  logic signed [2:0] base_slope;
  logic signed [8:0] slope9;
  logic signed [8:0] delta9;
  logic reload;
  logic signed [8:0] start_sin9;
  logic signed [8:0] start_cos9;
  logic signed [8:0] mag_old;
  logic signed [8:0] mag_next;
  logic [5:0] awaddr_ff;
  logic aw_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_held_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic nxt_aw_held;
  logic nxt_w_held;
  logic nxt_bvalid;
  logic wr_mapped;
  logic table_wr;
  logic [5:0] araddr_ff;
  logic rd_pend_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic ar_take;
  logic nxt_rvalid;
  logic [31:0] bus_word;

  // ==========================================================
  // position arithmetic for the coil being walked
  assign cos_offset = {{2{start_cfg_ff[COS_OFS_LSB + 7]}}, start_cfg_ff[COS_OFS_LSB +: 8]};
  assign walk_b = (state_ff == ST_FETCH_B) || (state_ff == ST_APPLY_B);
  assign old_b = pos_ff + QUARTER_POS + cos_offset;
  assign new_b = new_pos_ff + QUARTER_POS + cos_offset;
  assign cur_old = walk_b ? old_b : pos_ff;
  assign cur_new = walk_b ? new_b : new_pos_ff;
  assign idx_old = quarter_index(cur_old);
  assign idx_new = quarter_index(cur_new);
  assign rising = idx_new > idx_old;
  // the increment between two neighbours lives at the lower index
  assign walk_k = rising ? idx_old : idx_new;
  assign walk_index = walk_k[7:0];
  assign table_bit = walk_word[walk_index[4:0]];

  wave_table_mem #(
    .WORDS(TABLE_WORDS),
    .WIDTH(WORD_W)
  ) u_table (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(table_wr),
    .wr_addr(awaddr_ff[4:2]),
    .wr_data(wdata_ff),
    .wr_strb(wstrb_ff),
    .bus_addr(s_axi_araddr[4:2]),
    .bus_data(bus_word),
    .walk_addr(walk_index[7:5]),
    .walk_data(walk_word)
  );

  wave_segment_pick u_segment (
    .seg_select(seg_select_ff),
    .index(walk_index),
    .segment(segment),
    .base_slope(base_slope)
  );

  // ==========================================================
  // increment and reload
  assign slope9 = {{6{base_slope[2]}}, base_slope};
  assign delta9 = slope9 + {8'h00, table_bit};
  assign reload = (new_pos_ff == POS_ZERO);
  assign start_sin9 = {1'b0, start_cfg_ff[SINE_START_VALUE_LSB +: START_W]};
  assign start_cos9 = {1'b0, start_cfg_ff[START_COS_LSB +: START_W]};
  assign mag_old = walk_b ? mag_b_ff : mag_a_ff;

  always_comb begin
    if (reload) begin
      mag_next = walk_b ? start_cos9 : start_sin9;
    end else if (rising) begin
      mag_next = mag_old + delta9;
    end else begin
      mag_next = mag_old - delta9;
    end
  end

  // ==========================================================
  // walk sequencer; steps arriving while busy are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: if (step_pulse) state_ff <= ST_FETCH_A;
        ST_FETCH_A: state_ff <= ST_APPLY_A;
        ST_APPLY_A: state_ff <= ST_FETCH_B;
        ST_FETCH_B: state_ff <= ST_APPLY_B;
        ST_APPLY_B: state_ff <= ST_IDLE;
      endcase
    end
  end

  // microstep counter wraps modulo the full period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_ff <= POS_ZERO;
      new_pos_ff <= POS_ZERO;
    end else if (state_ff == ST_IDLE && step_pulse) begin
      new_pos_ff <= step_dir ? pos_ff + POS_ONE : pos_ff - POS_ONE;
    end else if (state_ff == ST_APPLY_B) begin
      pos_ff <= new_pos_ff;
    end
  end

  // quarter-wave magnitudes, one coil per apply state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mag_a_ff <= {1'b0, START_RESET[SINE_START_VALUE_LSB +: START_W]};
      mag_b_ff <= {1'b0, START_RESET[START_COS_LSB +: START_W]};
    end else if (state_ff == ST_APPLY_A) begin
      mag_a_ff <= mag_next;
    end else if (state_ff == ST_APPLY_B) begin
      mag_b_ff <= mag_next;
    end
  end

  // both currents published together with the counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coil_a_ff <= {1'b0, START_RESET[SINE_START_VALUE_LSB +: START_W]};
      coil_b_ff <= {1'b0, START_RESET[START_COS_LSB +: START_W]};
    end else if (state_ff == ST_APPLY_B) begin
      coil_a_ff <= new_pos_ff[9] ? -mag_a_ff : mag_a_ff;
      coil_b_ff <= new_b[9] ? -mag_next : mag_next;
    end
  end

  // ==========================================================
  // write channel: address and data taken in either order
  assign aw_take = s_axi_awvalid && awready_ff;
  assign w_take = s_axi_wvalid && wready_ff;
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_mapped = awaddr_ff[5:2] <= OFS_CURRENT[5:2];
  assign table_wr = do_write && !awaddr_ff[5];

  always_comb begin
    nxt_aw_held = !do_write && (aw_held_ff || aw_take);
    nxt_w_held = !do_write && (w_held_ff || w_take);
    nxt_bvalid = do_write || (bvalid_ff && !s_axi_bready);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= OFS_TABLE0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      // one write in flight: ready stays low until the response is gone
      awready_ff <= !nxt_aw_held && !nxt_bvalid;
      wready_ff <= !nxt_w_held && !nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (do_write) bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      if (aw_take) awaddr_ff <= s_axi_awaddr;
      if (w_take) wdata_ff <= s_axi_wdata;
      if (w_take) wstrb_ff <= s_axi_wstrb;
    end
  end

  // configuration words; status words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg_select_ff <= SELECT_RESET;
      start_cfg_ff <= START_RESET;
    end else if (do_write) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_ff[b] && awaddr_ff[5:2] == OFS_SELECT[5:2]) begin
          seg_select_ff[8*b +: 8] <= wdata_ff[8*b +: 8];
        end
        if (wstrb_ff[b] && awaddr_ff[5:2] == OFS_START[5:2]) begin
          start_cfg_ff[8*b +: 8] <= wdata_ff[8*b +: 8];
        end
      end
    end
  end

  // ==========================================================
  // read channel: table port answers one edge after the take
  assign ar_take = s_axi_arvalid && arready_ff;
  assign nxt_rvalid = rd_pend_ff || (rvalid_ff && !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_ff <= 1'b0;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      araddr_ff <= OFS_TABLE0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else begin
      rd_pend_ff <= ar_take;
      arready_ff <= !ar_take && !rd_pend_ff && !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_take) araddr_ff <= s_axi_araddr;
      if (rd_pend_ff) begin
        rresp_ff <= RESP_OKAY;
        if (!araddr_ff[5]) begin
          rdata_ff <= bus_word;
        end else if (araddr_ff[5:2] == OFS_SELECT[5:2]) begin
          rdata_ff <= seg_select_ff;
        end else if (araddr_ff[5:2] == OFS_START[5:2]) begin
          rdata_ff <= start_cfg_ff;
        end else if (araddr_ff[5:2] == OFS_COUNTER[5:2]) begin
          rdata_ff <= {22'h000000, pos_ff};
        end else if (araddr_ff[5:2] == OFS_CURRENT[5:2]) begin
          rdata_ff <= {7'h00, coil_b_ff, 7'h00, coil_a_ff};
        end else begin
          rdata_ff <= '0;
          rresp_ff <= RESP_SLVERR;
        end
      end
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign microstep_counter = pos_ff;
  assign coil_a_current = coil_a_ff;
  assign coil_b_current = coil_b_ff;

  // ==========================================================
  // checks
  property p_count_step;
    @(posedge aclk) disable iff (!aresetn)
    $changed(pos_ff) |-> (pos_ff == $past(pos_ff) + POS_ONE || pos_ff == $past(pos_ff) - POS_ONE);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter moved by more than one");

  property p_sign_a;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_IDLE) |-> (coil_a_ff == (pos_ff[9] ? -mag_a_ff : mag_a_ff));
  endproperty
  a_sign_a: assert property (p_sign_a) else $error("coil a sign wrong for quadrant");

  property p_reload_a;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_APPLY_A && reload) |=> (mag_a_ff == $past(start_sin9));
  endproperty
  a_reload_a: assert property (p_reload_a) else $error("coil a not reloaded at zero");

  property p_reload_b;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_APPLY_B && reload) |=> (mag_b_ff == $past(start_cos9));
  endproperty
  a_reload_b: assert property (p_reload_b) else $error("coil b not reloaded at zero");

  property p_increment;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_APPLY_A && !reload && rising)
      |=> (mag_a_ff == $past(mag_a_ff) + $past(slope9) + {8'h00, $past(table_bit)});
  endproperty
  a_increment: assert property (p_increment) else $error("increment not slope plus bit");

  property p_slope_range;
    @(posedge aclk) disable iff (!aresetn)
    (base_slope >= -3'sh1) && (base_slope <= 3'sh2);
  endproperty
  a_slope_range: assert property (p_slope_range) else $error("base slope out of range");

  property p_first_segment;
    @(posedge aclk) disable iff (!aresetn)
    (walk_index < seg_select_ff[SEL_BOUND1_LSB +: BOUND_W]) |-> (segment == 2'h0);
  endproperty
  a_first_segment: assert property (p_first_segment) else $error("segment 0 not chosen");

  property p_step_done;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == ST_IDLE && step_pulse) |-> ##5 (state_ff == ST_IDLE && pos_ff != $past(pos_ff, 5));
  endproperty
  a_step_done: assert property (p_step_done) else $error("step not completed in five cycles");

  property p_reset_values;
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (seg_select_ff == SELECT_RESET && start_cfg_ff == START_RESET);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("config reset value wrong");
endmodule : wave_table_core

/* File: verification/wave_step_source.sv */
`timescale 1ns/100ps
// ====================
// step sequencer stand-in
module wave_step_source (
  input wire logic aclk,
  output logic step_pulse,
  output logic step_dir
);
  // quiet at time zero
  initial begin
    step_pulse = 1'h0;
    step_dir = 1'h0;
  end
  // one-cycle request, then a hold-off of gap cycles
  task automatic issue(input logic dir, input int gap);
    @(posedge aclk);
    step_pulse <= 1'h1;
    step_dir <= dir;
    @(posedge aclk);
    step_pulse <= 1'h0;
    step_dir <= ~dir; // direction only means something beside the pulse
    repeat (gap) @(posedge aclk);
  endtask : issue
endmodule : wave_step_source

/* File: verification/microstep_wave_table_bench.sv */
`timescale 1ns/100ps
// ====================
// bench top: bus master, reference wave, checks
module microstep_wave_table_bench
  import wave_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic [5:0] s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic step_pulse, step_dir;
  logic [POS_W-1:0] microstep_counter;
  logic signed [CUR_W-1:0] coil_a_current, coil_b_current;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int cnt, ea, eb, ma, mb;
  int la = 0;
  int lb = 0;
  logic [31:0] tbl [8];
  logic [31:0] sel, stc;

  wave_table_core DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .step_pulse, .step_dir, .microstep_counter,
    .coil_a_current, .coil_b_current);
  wave_step_source seq (.aclk, .step_pulse, .step_dir);

  // 10 MHz clock
  always #50 aclk = ~aclk;

  // hang guard, well above the planned run of about 22000 cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      $display("timeout at cycle %0d", cycles);
      wrap_up();
    end
  end

  // ====================
  // reporting
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  // ====================
  // bus master: hold each channel until its own ready
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        done = 1'h1;
      end
    end
  endtask : rd

  task automatic rchk(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk($sformatf("rdata %h", a), e, d);
    chk($sformatf("rresp %h", a), er, r);
  endtask : rchk

  // ====================
  // reference wave, rebuilt from the table bits on every call
  function automatic int qv(input int i);
    int v, sg;
    v = stc[7:0];
    for (int k = 0; k < i; k++) begin
      sg = (k < sel[15:8]) ? 0 : (k < sel[23:16]) ? 1 : (k < sel[31:24]) ? 2 : 3;
      v += int'(sel[2 * sg +: 2]) - 1 + tbl[k / 32][k % 32];
    end
    return v;
  endfunction : qv

  // quarter index of a full-wave position; odd quadrants run backwards
  function automatic int qi(input int p);
    int x;
    x = p & 255;
    return ((p >> 8) & 1) ? 256 - x : x;
  endfunction : qi

  function automatic int peak();
    int m, v;
    m = 0;
    for (int i = 0; i <= 256; i++) begin
      v = qv(i);
      if (v < 0) v = -v;
      if (v > m) m = v;
    end
    return m;
  endfunction : peak

  // magnitudes move by table increments, re-anchored when the count lands on zero;
  // the quadrant sign is applied last, so a start value off the table mirrors too
  task automatic mstep(input logic dir);
    int nc, o;
    nc = (cnt + (dir ? 1 : 1023)) % 1024;
    o = 256 + int'($signed(stc[31:24]));
    if (nc == 0) begin
      ma = stc[7:0];
      mb = stc[23:16];
    end else begin
      ma += qv(qi(nc)) - qv(qi(cnt));
      mb += qv(qi(nc + o)) - qv(qi(cnt + o));
    end
    ea = ((nc >> 9) & 1) ? -ma : ma;
    eb = (((nc + o) >> 9) & 1) ? -mb : mb;
    cnt = nc;
  endtask : mstep

  task automatic look();
    chk("counter", cnt, microstep_counter);
    chk("coil a", 9'(ea), coil_a_current);
    chk("coil b", 9'(eb), coil_b_current);
  endtask : look

  task automatic walk(input int up, input int dn);
    for (int n = 0; n < up + dn; n++) begin
      seq.issue(n < up, 6 + int'($urandom % 4));
      mstep(n < up);
      look();
      // summed coil magnitudes stand in for the per-coil load readings
      la += (ea < 0) ? -ea : ea;
      lb += (eb < 0) ? -eb : eb;
    end
    $display("walk of %0d steps done", up + dn);
  endtask : walk

  // ====================
  // main sequence
  initial begin
    logic [1:0] r;
    int o;
    void'($urandom(32'h0960));
    tbl = '{32'hAAAAB554, 32'h4A9554AA, 32'h24492929, 32'h10104222,
      32'h0FBFFFFF, 32'h49295556, 32'h00000000, 32'h00404222};
    sel = 32'hFFFF8056;
    stc = 32'h00F70000;
    cnt = 0;
    ea = 0;
    eb = 247;
    ma = 0;
    mb = 247;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 8; i++) rchk(6'(4 * i), tbl[i], RESP_OKAY);
    rchk(OFS_SELECT, sel, RESP_OKAY);
    rchk(OFS_START, stc, RESP_OKAY);
    rchk(OFS_CURRENT, 32'h00F70000, RESP_OKAY);
    look();
    $display("reset values done");
    // unmapped holes refuse, status words ignore writes
    rchk(6'h30, 32'h0, RESP_SLVERR);
    wr(6'h3C, 32'hFFFFFFFF, 4'hF, r);
    chk("bresp hole", RESP_SLVERR, r);
    wr(OFS_COUNTER, 32'h155, 4'hF, r);
    chk("bresp status", RESP_OKAY, r);
    rchk(OFS_COUNTER, 32'h0, RESP_OKAY);
    $display("bus refusals done");
    walk(1030, 100);
    // second request inside the busy window must vanish
    seq.issue(1'h1, 1);
    mstep(1'h1);
    seq.issue(1'h1, 1);
    seq.issue(1'h1, 6);
    mstep(1'h1);
    look();
    $display("busy drop done");
    // new wave: slopes -1, 0, 1, 2 in segments 0 to 3
    o = int'($urandom % 35) - 17;
    stc = {8'(o), (o >= -10 && o <= 9) ? 8'hF7 : 8'hF6, 16'h0000};
    sel = 32'hC08040E4;
    do for (int i = 0; i < 8; i++) tbl[i] = $urandom & $urandom;
    while (peak() > 248);
    for (int i = 0; i < 8; i++) wr(6'(4 * i), tbl[i], 4'hF, r);
    wr(OFS_SELECT, sel, 4'hF, r);
    wr(OFS_START, {stc[31:24], 24'hA5A5A5}, 4'h8, r);
    wr(OFS_START, {8'h5A, stc[23:0]}, 4'h7, r);
    for (int i = 0; i < 8; i++) rchk(6'(4 * i), tbl[i], RESP_OKAY);
    rchk(OFS_SELECT, sel, RESP_OKAY);
    rchk(OFS_START, stc, RESP_OKAY);
    walk(1100, 60);
    // one phase-tuning pass: nudge the offset toward balanced coil loads
    o += (la > lb) ? 1 : -1;
    o = (o > 17) ? 17 : (o < -17) ? -17 : o;
    stc = {8'(o), (o >= -10 && o <= 9) ? 8'hF7 : 8'hF6, 16'h0000};
    wr(OFS_START, stc, 4'hC, r);
    chk("bresp start", RESP_OKAY, r);
    rchk(OFS_START, stc, RESP_OKAY);
    walk(40, 0);
    wrap_up();
  end
endmodule : microstep_wave_table_bench
